// File: design/sft_top.sv
// sample buffer status flags, limit checks and register readout
`timescale 1ns/1ps
module sft_top (
  input  wire logic                               CLOCK,
  input  wire logic                               RESET_N,
  // enable and clear
  input  wire logic                               FIFO_ENABLE,
  input  wire logic                               FIFO_CLEAR,
  // results in, valid and ready
  input  wire logic                               CONV_VALID,
  input  wire logic [sft_pkg::WORD_W-1:0]         CONV_DATA,
  input  wire logic [sft_pkg::CHAN_W-1:0]         CONV_CHANNEL,
  output logic                                    CONV_READY,
  input  wire logic [sft_pkg::NUM_CHAN-1:0]       CHANNEL_LIMIT_CHECK_ENABLE,
  // register port
  input  wire logic [sft_pkg::ADDR_W-1:0]         REG_ADDR,
  input  wire logic                               REG_WRITE,
  input  wire logic                               REG_READ,
  input  wire logic [sft_pkg::WORD_W-1:0]         REG_WDATA,
  output logic [sft_pkg::WORD_W-1:0]              REG_RDATA,
  output logic                                    REG_RVALID,
  // status and occupancy
  output logic                                    EMPTY_FLAG,
  output logic                                    EMPTY_IRQ,
  output logic                                    UPPER_LIMIT_HIT,
  output logic                                    LOWER_LIMIT_HIT,
  output logic                                    CLEAR_DONE,
  output logic [sft_pkg::LEVEL_W-1:0]             FIFO_LEVEL
);

  // ************************************************************
  // declarations
  // ************************************************************
  // fill state; the empty flag reads it
  typedef enum logic [1:0] {
    ST_OFF,     // buffer disabled, held empty
    ST_IDLE,    // enabled, nothing stored
    ST_FILLED   // enabled, one or more entries stored
  } sft_state_e;

  // registered state, next values
  sft_state_e          state_reg,      state_next;
  sft_pkg::sft_word_t  limits_reg,     limits_next;
  sft_pkg::sft_word_t  rdata_reg,      rdata_next;
  logic                rvalid_reg,     rvalid_next;
  logic                empty_reg,      empty_next;
  logic                empty_irq_reg,  empty_irq_next;
  logic                upper_hit_reg,  upper_hit_next;
  logic                lower_hit_reg,  lower_hit_next;
  logic                clear_done_reg, clear_done_next;
  logic                ready_reg,      ready_next;
  // local copy of the buffer level
  logic [sft_pkg::LEVEL_W-1:0] level_reg, level_next;

  // helpers
  sft_pkg::sft_limit_t upper_limit_value;
  sft_pkg::sft_limit_t lower_limit_value;
  sft_pkg::sft_limit_t result_msbs;
  logic                check_enabled;
  // buffer handshakes
  logic                push;
  logic                pop;
  logic                flush;
  logic                clear_taken;
  // address decode
  logic                read_port_hit;
  logic                limits_read_hit;
  logic                limits_write_hit;
  // limit crossings this edge
  logic                upper_event;
  logic                lower_event;
  logic                emptied;

  // carrier to the buffer
  sft_fifo_if #(
    .WIDTH   (sft_pkg::WORD_W),
    .LEVEL_W (sft_pkg::LEVEL_W)
  ) buf_if ();

  // ************************************************************
  // sample buffer
  // ************************************************************
  // four entries, no flags inside
  sft_fifo #(
    .WIDTH   (sft_pkg::WORD_W),
    .DEPTH   (sft_pkg::FIFO_DEPTH),
    .LEVEL_W (sft_pkg::LEVEL_W)
  ) u_buffer (
    .clk   (CLOCK),
    .rst_n (RESET_N),
    .port  (buf_if.buffer)
  );

  // ************************************************************
  // address decode
  // ************************************************************
  // register accesses, keyed on the two mapped addresses
  // decoded in every cycle the strobe is high, not on its edge
  assign read_port_hit    = REG_READ  &
                            (REG_ADDR == sft_pkg::ADDR_READ_PORT);
  assign limits_read_hit  = REG_READ  &
                            (REG_ADDR == sft_pkg::ADDR_LIMITS);
  assign limits_write_hit = REG_WRITE &
                            (REG_ADDR == sft_pkg::ADDR_LIMITS);

  // writes to the data address are ignored
  // unmapped reads answer with zero

  // ************************************************************
  // buffer control
  // ************************************************************
  // a clear counts only while the buffer is enabled
  // a clear while disabled: no done pulse
  assign clear_taken = FIFO_CLEAR & FIFO_ENABLE;
  // disabling or clearing empties the buffer; flush beats push and pop
  assign flush = clear_taken | ~FIFO_ENABLE;
  // results enter only while the registered ready is high
  assign push  = CONV_VALID & ready_reg & ~flush;
  // a data read removes the head entry, if any
  assign pop   = read_port_hit & buf_if.out_valid & ~flush;
  // empty buffer: no pop, zero returned
  // a result offered with a clear is lost

  // buffer wiring
  // same push and pop as the level mirror
  assign buf_if.in_valid  = push;
  assign buf_if.in_data   = CONV_DATA;
  assign buf_if.out_ready = pop;
  assign buf_if.flush     = flush;

  // ************************************************************
  // limit comparison on incoming results
  // ************************************************************
  // limit fields and the compared slice of the stored result
  assign upper_limit_value =
    limits_reg[sft_pkg::UPPER_MSB:sft_pkg::UPPER_LSB];
  assign lower_limit_value =
    limits_reg[sft_pkg::LOWER_MSB:sft_pkg::LOWER_LSB];
  assign result_msbs =
    CONV_DATA[sft_pkg::WORD_W-1:sft_pkg::RESULT_LSB];
  // top twelve bits meet the limits

  // per channel enable picked by the result's channel number
  assign check_enabled = CHANNEL_LIMIT_CHECK_ENABLE[CONV_CHANNEL];
  // four bits pick one of sixteen enables

  // a result being stored crosses a limit
  assign upper_event = push & check_enabled &
                       (result_msbs >= upper_limit_value);
  assign lower_event = push & check_enabled &
                       (result_msbs <= lower_limit_value);

  // judged on storing, not on readout
  // limits quasi-static: flush after a change
  // unsigned compare

  // ************************************************************
  // occupancy and state
  // ************************************************************
  // occupancy after this edge, mirroring the buffer's own count
  // lets the flags look one edge ahead
  // flush first, then push or pop
  always_comb begin
    level_next = buf_if.level;
    if (flush) begin
      level_next = sft_pkg::LEVEL_ZERO;
    end else if (push && !pop) begin
      level_next = buf_if.level + sft_pkg::LEVEL_ONE;
    end else if (pop && !push) begin
      level_next = buf_if.level - sft_pkg::LEVEL_ONE;
    end
  end

  // buffer is empty after this edge
  assign emptied = (level_next == sft_pkg::LEVEL_ZERO);
  // also zero through a flush

  // enable and fill state of the buffer
  // any disable returns to off
  // idle and filled swap on level
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (FIFO_ENABLE) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (!FIFO_ENABLE) begin
          state_next = ST_OFF;
        end else if (!emptied) begin
          state_next = ST_FILLED;
        end
      end
      ST_FILLED: begin
        if (!FIFO_ENABLE) begin
          state_next = ST_OFF;
        end else if (emptied) begin
          state_next = ST_IDLE;
        end
      end
      // unused code falls back to off
      default: begin
        state_next = ST_OFF;
      end
    endcase
  end

  // ************************************************************
  // status flags
  // ************************************************************
  // empty flag and its interrupt move together
  // empty unless entries will be held
  always_comb begin
    empty_next     = (state_next != ST_FILLED);
    empty_irq_next = empty_next;
  end

  // limit hits: a new event outweighs the clear on emptying
  // sticky until the buffer empties
  always_comb begin
    upper_hit_next = upper_hit_reg;
    lower_hit_next = lower_hit_reg;
    if (emptied) begin
      upper_hit_next = 1'b0;
      lower_hit_next = 1'b0;
    end
    if (upper_event) begin
      upper_hit_next = 1'b1;
    end
    if (lower_event) begin
      lower_hit_next = 1'b1;
    end
  end

  // clear completion pulse and input ready
  // ready drops at the edge that takes a clear or fills the buffer
  // done pulses once per clear
  always_comb begin
    clear_done_next = clear_taken;
    ready_next      = FIFO_ENABLE & ~FIFO_CLEAR &
                      (level_next != sft_pkg::LEVEL_FULL);
  end

  // ************************************************************
  // register file
  // ************************************************************
  // limit register written by the host, held otherwise
  // a write lands at the next edge
  // other addresses are read only
  always_comb begin
    limits_next = limits_reg;
    if (limits_write_hit) begin
      limits_next = REG_WDATA;
    end
  end

  // read data: head entry, limits, or zero when unmapped or empty
  // data stand until the next read
  // valid answers every read, mapped or not
  always_comb begin
    rdata_next  = rdata_reg;
    rvalid_next = REG_READ;
    if (read_port_hit) begin
      if (pop) begin
        rdata_next = buf_if.out_data;
      end else begin
        rdata_next = sft_pkg::READ_PORT_RESET;
      end
    end else if (limits_read_hit) begin
      rdata_next = limits_reg;
    end else if (REG_READ) begin
      rdata_next = '0;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  // every output is taken from here
  // constants only in reset
  // all top-level state in one register bank; the buffer keeps its own
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg      <= ST_OFF;
      limits_reg     <= sft_pkg::LIMITS_RESET;
      rdata_reg      <= sft_pkg::READ_PORT_RESET;
      rvalid_reg     <= 1'b0;
      empty_reg      <= sft_pkg::EMPTY_RESET;
      empty_irq_reg  <= sft_pkg::EMPTY_RESET;
      upper_hit_reg  <= 1'b0;
      lower_hit_reg  <= 1'b0;
      clear_done_reg <= 1'b0;
      ready_reg      <= 1'b0;
      level_reg      <= sft_pkg::LEVEL_ZERO;
    end else begin
      state_reg      <= state_next;
      limits_reg     <= limits_next;
      rdata_reg      <= rdata_next;
      rvalid_reg     <= rvalid_next;
      empty_reg      <= empty_next;
      empty_irq_reg  <= empty_irq_next;
      upper_hit_reg  <= upper_hit_next;
      lower_hit_reg  <= lower_hit_next;
      clear_done_reg <= clear_done_next;
      ready_reg      <= ready_next;
      level_reg      <= level_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // plain wires from the registers
  assign CONV_READY      = ready_reg;
  assign REG_RDATA       = rdata_reg;
  assign REG_RVALID      = rvalid_reg;
  assign EMPTY_FLAG      = empty_reg;
  assign EMPTY_IRQ       = empty_irq_reg;
  assign UPPER_LIMIT_HIT = upper_hit_reg;
  assign LOWER_LIMIT_HIT = lower_hit_reg;
  assign CLEAR_DONE      = clear_done_reg;
  assign FIFO_LEVEL      = level_reg;

endmodule // sft_top

// File: design/sft_pkg.sv
// constants shared by the sample fifo status and readout logic
package sft_pkg;

  // ************************************************************
  // data widths
  // ************************************************************
  localparam int unsigned WORD_W     = 24;  // stored result width
  localparam int unsigned LIMIT_W    = 12;  // one limit field
  localparam int unsigned ADDR_W     = 8;   // register address width
  localparam int unsigned CHAN_W     = 4;   // channel number width
  localparam int unsigned NUM_CHAN   = 16;  // channel count
  localparam int unsigned FIFO_DEPTH = 4;   // entries in the buffer
  localparam int unsigned LEVEL_W    = 3;   // holds 0 .. FIFO_DEPTH

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [ADDR_W-1:0] ADDR_LIMITS    = 8'h3C;
  localparam logic [ADDR_W-1:0] ADDR_READ_PORT = 8'h3D;

  // ************************************************************
  // field layout of the limit register
  // ************************************************************
  localparam int unsigned UPPER_LSB = 12;  // upper limit in [23:12]
  localparam int unsigned UPPER_MSB = 23;
  localparam int unsigned LOWER_LSB = 0;   // lower limit in [11:0]
  localparam int unsigned LOWER_MSB = 11;
  localparam int unsigned RESULT_LSB = 12; // result bits compared

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [WORD_W-1:0]  LIMITS_RESET    = 24'hFF_F000;
  localparam logic [WORD_W-1:0]  READ_PORT_RESET = 24'h00_0000;
  localparam logic               EMPTY_RESET     = 1'b1;
  localparam logic [LEVEL_W-1:0] LEVEL_ZERO      = 3'h0;
  localparam logic [LEVEL_W-1:0] LEVEL_ONE       = 3'h1;
  localparam logic [LEVEL_W-1:0] LEVEL_FULL      = 3'h4;

  typedef logic [WORD_W-1:0]  sft_word_t;
  typedef logic [LIMIT_W-1:0] sft_limit_t;

endpackage

// File: design/sft_fifo_if.sv
// carrier between the readout logic and its sample buffer
`timescale 1ns/1ps
interface sft_fifo_if #(
  parameter int unsigned WIDTH   = 24,
  parameter int unsigned LEVEL_W = 3
);
  logic               in_valid;
  logic               in_ready;
  logic [WIDTH-1:0]   in_data;
  logic               out_valid;
  logic               out_ready;
  logic [WIDTH-1:0]   out_data;
  logic               flush;
  logic [LEVEL_W-1:0] level;

  // buffer side
  modport buffer (
    input  in_valid, in_data, out_ready, flush,
    output in_ready, out_valid, out_data, level
  );

  // user side
  modport user (
    output in_valid, in_data, out_ready, flush,
    input  in_ready, out_valid, out_data, level
  );
endinterface

// File: design/sft_fifo.sv
// small first-in first-out buffer of stored results
`timescale 1ns/1ps
module sft_fifo #(
  parameter int unsigned WIDTH   = 24,
  parameter int unsigned DEPTH   = 4,
  parameter int unsigned LEVEL_W = 3
) (
  input  wire logic clk,
  input  wire logic rst_n,
  sft_fifo_if.buffer port
);
  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0]   mem_reg  [DEPTH];
  logic [WIDTH-1:0]   mem_next [DEPTH];
  logic [PTR_W-1:0]   wr_ptr_reg, wr_ptr_next;
  logic [PTR_W-1:0]   rd_ptr_reg, rd_ptr_next;
  logic [LEVEL_W-1:0] level_reg,  level_next;
  logic               push;
  logic               pop;

  // ************************************************************
  // handshakes and next state
  // ************************************************************
  assign port.in_ready  = (level_reg != LEVEL_W'(DEPTH));
  assign port.out_valid = (level_reg != '0);
  assign port.out_data  = mem_reg[rd_ptr_reg];
  assign port.level     = level_reg;
  assign push = port.in_valid & port.in_ready & ~port.flush;
  assign pop  = port.out_ready & port.out_valid & ~port.flush;

  // pointers wrap at depth; flush empties without touching storage
  always_comb begin
    mem_next    = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    level_next  = level_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = port.in_data;
      wr_ptr_next = (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0
                                                    : wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0
                                                    : rd_ptr_reg + 1'b1;
    end
    if (port.flush) begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      level_next  = '0;
    end else if (push && !pop) begin
      level_next = level_reg + 1'b1;
    end else if (pop && !push) begin
      level_next = level_reg - 1'b1;
    end
  end

  // state registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg  <= '0;
    end else begin
      mem_reg    <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      level_reg  <= level_next;
    end
  end
endmodule // sft_fifo

// File: verif/sft_props.sv
// concurrent checks on the sample buffer status and readout ports
`timescale 1ns/1ps
module sft_props (
  input logic                         CLOCK,
  input logic                         RESET_N,
  input logic                         FIFO_ENABLE,
  input logic                         FIFO_CLEAR,
  input logic                         CONV_VALID,
  input logic                         CONV_READY,
  input logic [sft_pkg::CHAN_W-1:0]   CONV_CHANNEL,
  input logic [sft_pkg::NUM_CHAN-1:0] CHANNEL_LIMIT_CHECK_ENABLE,
  input logic [sft_pkg::ADDR_W-1:0]   REG_ADDR,
  input logic                         REG_READ,
  input logic                         REG_RVALID,
  input logic                         EMPTY_FLAG,
  input logic                         EMPTY_IRQ,
  input logic                         UPPER_LIMIT_HIT,
  input logic                         LOWER_LIMIT_HIT,
  input logic                         CLEAR_DONE,
  input logic [sft_pkg::LEVEL_W-1:0]  FIFO_LEVEL
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  // ******************************************************
  // properties
  // ******************************************************
  sequence s_take;
    CONV_VALID && CONV_READY;
  endsequence
  property p_irq; EMPTY_IRQ == EMPTY_FLAG; endproperty
  property p_full; (FIFO_LEVEL != sft_pkg::LEVEL_ZERO) |-> !EMPTY_FLAG;
  endproperty
  property p_none; (FIFO_LEVEL == sft_pkg::LEVEL_ZERO) |-> EMPTY_FLAG;
  endproperty
  property p_off;
    !FIFO_ENABLE |=> EMPTY_FLAG && (FIFO_LEVEL == sft_pkg::LEVEL_ZERO);
  endproperty
  property p_clr; FIFO_CLEAR && FIFO_ENABLE |=> CLEAR_DONE && EMPTY_FLAG;
  endproperty
  property p_done; CLEAR_DONE |-> $past(FIFO_CLEAR) && $past(FIFO_ENABLE);
  endproperty
  property p_rv; REG_READ |-> ##1 REG_RVALID; endproperty
  property p_rv0; !REG_READ |=> !REG_RVALID; endproperty
  property p_last;
    REG_READ && (REG_ADDR == sft_pkg::ADDR_READ_PORT) && !CONV_VALID
      && (FIFO_LEVEL == sft_pkg::LEVEL_ONE) |=> EMPTY_FLAG;
  endproperty
  property p_hit0; EMPTY_FLAG |-> !UPPER_LIMIT_HIT && !LOWER_LIMIT_HIT;
  endproperty
  property p_nochk;
    s_take ##0 (!CHANNEL_LIMIT_CHECK_ENABLE[CONV_CHANNEL] && !UPPER_LIMIT_HIT
      && !LOWER_LIMIT_HIT) |=> !UPPER_LIMIT_HIT && !LOWER_LIMIT_HIT;
  endproperty
  property p_push;
    s_take ##0 (FIFO_ENABLE && !FIFO_CLEAR && !REG_READ
      && FIFO_LEVEL != sft_pkg::LEVEL_FULL)
      |=> FIFO_LEVEL == $past(FIFO_LEVEL) + sft_pkg::LEVEL_ONE;
  endproperty

  // ******************************************************
  // assertions and covers
  // ******************************************************
  a_irq: assert property (p_irq)
    else $error("empty interrupt differs from empty flag");
  a_full: assert property (p_full)
    else $error("empty flag set while entries stored");
  a_none: assert property (p_none)
    else $error("empty flag clear with no entries");
  a_off: assert property (p_off)
    else $error("disabled buffer not empty");
  a_clr: assert property (p_clr)
    else $error("clear did not complete");
  a_done: assert property (p_done)
    else $error("clear done without a clear");
  a_rv: assert property (p_rv)
    else $error("read without valid answer");
  a_rv0: assert property (p_rv0)
    else $error("read valid without a read");
  a_last: assert property (p_last)
    else $error("empty flag not set on last read");
  a_hit0: assert property (p_hit0)
    else $error("limit hit while buffer empty");
  a_nochk: assert property (p_nochk)
    else $error("limit hit on unchecked channel");
  a_push: assert property (p_push)
    else $error("level did not follow a store");
  c_clear: cover property (CLEAR_DONE);
  c_upper: cover property ($rose(UPPER_LIMIT_HIT));
  c_full: cover property (FIFO_LEVEL == sft_pkg::LEVEL_FULL);
endmodule // sft_props

// File: verif/sft_host.sv
// host model issuing register reads and writes to the block
`timescale 1ns/1ps
module sft_host (
  input  logic                       clk,
  output logic [sft_pkg::ADDR_W-1:0] reg_addr,
  output logic                       reg_write,
  output logic                       reg_read,
  output sft_pkg::sft_word_t         reg_wdata,
  input  sft_pkg::sft_word_t         reg_rdata,
  input  logic                       reg_rvalid
);
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_wdata = 24'h00_0000;
  end

  // one read: strobe for one cycle, take data with the valid pulse
  task automatic rd(input logic [7:0] a, output sft_pkg::sft_word_t d,
                    output logic v);
    @(negedge clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    reg_addr = ~a;  // released bus shows a changed pattern
    v = reg_rvalid;
    d = reg_rdata;
  endtask

  // one write: strobe for one cycle, then release the bus
  task automatic wr(input logic [7:0] a, input sft_pkg::sft_word_t d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule // sft_host

// File: verif/tb.sv
// testbench for the sample buffer status flags and readout
`timescale 1ns/1ps
module tb;
  logic                         CLOCK, RESET_N, FIFO_ENABLE, FIFO_CLEAR;
  logic                         CONV_VALID, CONV_READY, REG_WRITE, REG_READ;
  logic                         REG_RVALID, EMPTY_FLAG, EMPTY_IRQ;
  logic                         UPPER_LIMIT_HIT, LOWER_LIMIT_HIT, CLEAR_DONE;
  sft_pkg::sft_word_t           CONV_DATA, REG_WDATA, REG_RDATA, lim;
  logic [sft_pkg::CHAN_W-1:0]   CONV_CHANNEL;
  logic [sft_pkg::NUM_CHAN-1:0] CHANNEL_LIMIT_CHECK_ENABLE;
  logic [sft_pkg::ADDR_W-1:0]   REG_ADDR;
  logic [sft_pkg::LEVEL_W-1:0]  FIFO_LEVEL;
  sft_pkg::sft_word_t           q[$];
  logic                         up_m, lo_m;
  int                           num_errors, compares;

  sft_top sft_top_i (.CLOCK(CLOCK), .RESET_N(RESET_N),
    .FIFO_ENABLE(FIFO_ENABLE), .FIFO_CLEAR(FIFO_CLEAR),
    .CONV_VALID(CONV_VALID), .CONV_DATA(CONV_DATA),
    .CONV_CHANNEL(CONV_CHANNEL), .CONV_READY(CONV_READY),
    .CHANNEL_LIMIT_CHECK_ENABLE(CHANNEL_LIMIT_CHECK_ENABLE),
    .REG_ADDR(REG_ADDR), .REG_WRITE(REG_WRITE), .REG_READ(REG_READ),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .EMPTY_FLAG(EMPTY_FLAG), .EMPTY_IRQ(EMPTY_IRQ),
    .UPPER_LIMIT_HIT(UPPER_LIMIT_HIT), .LOWER_LIMIT_HIT(LOWER_LIMIT_HIT),
    .CLEAR_DONE(CLEAR_DONE), .FIFO_LEVEL(FIFO_LEVEL));
  sft_host sft_host_i (.clk(CLOCK), .reg_addr(REG_ADDR),
    .reg_write(REG_WRITE), .reg_read(REG_READ), .reg_wdata(REG_WDATA),
    .reg_rdata(REG_RDATA), .reg_rvalid(REG_RVALID));

  // clock of 50 ns period
  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end

  // ******************************************************
  // compare and closing tasks
  // ******************************************************
  task automatic chk_word(input string nm, input sft_pkg::sft_word_t e,
                          input sft_pkg::sft_word_t g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_flag(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic results;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ******************************************************
  // model and stimulus tasks
  // ******************************************************
  task automatic status;
    chk_word("level", 24'(q.size()), {21'h00_0000, FIFO_LEVEL});
    chk_flag("empty", q.size() == 0, EMPTY_FLAG);
    chk_flag("empty irq", q.size() == 0, EMPTY_IRQ);
    chk_flag("upper hit", up_m, UPPER_LIMIT_HIT);
    chk_flag("lower hit", lo_m, LOWER_LIMIT_HIT);
  endtask
  task automatic push(input sft_pkg::sft_word_t d, input logic [3:0] ch);
    int n;
    @(negedge CLOCK);
    CONV_VALID = 1'b1;
    CONV_DATA = d;
    CONV_CHANNEL = ch;
    n = 0;
    while (CONV_READY !== 1'b1 && n < 50) begin
      @(negedge CLOCK);
      n++;
    end
    chk_flag("conv ready", 1'b1, CONV_READY);
    @(negedge CLOCK);
    CONV_VALID = 1'b0;
    CONV_DATA = ~d;
    q.push_back(d);
    if (CHANNEL_LIMIT_CHECK_ENABLE[ch]) begin
      if (d[23:12] >= lim[23:12]) up_m = 1'b1;
      if (d[23:12] <= lim[11:0]) lo_m = 1'b1;
    end
    status();
  endtask
  task automatic pop;
    sft_pkg::sft_word_t d;
    logic v;
    sft_host_i.rd(sft_pkg::ADDR_READ_PORT, d, v);
    chk_word("data", q.pop_front(), d);
    if (q.size() == 0) {up_m, lo_m} = 2'b00;
    status();
  endtask
  task automatic clr;
    @(negedge CLOCK);
    FIFO_CLEAR = 1'b1;
    @(negedge CLOCK);
    FIFO_CLEAR = 1'b0;
    chk_flag("clear done", 1'b1, CLEAR_DONE);
    q.delete();
    {up_m, lo_m} = 2'b00;
    status();
  endtask

  // ******************************************************
  // main sequence
  // ******************************************************
  initial begin
    sft_pkg::sft_word_t d;
    logic v;
    {RESET_N, FIFO_ENABLE, FIFO_CLEAR, CONV_VALID} = 4'h0;
    CONV_DATA = 24'h00_0000;
    CONV_CHANNEL = 4'h0;
    CHANNEL_LIMIT_CHECK_ENABLE = 16'hffff;
    {up_m, lo_m} = 2'b00;
    lim = sft_pkg::LIMITS_RESET;
    void'($urandom(32'h828c_b11e));
    repeat (6) @(posedge CLOCK);
    @(negedge CLOCK);
    RESET_N = 1'b1;
    status();
    sft_host_i.rd(sft_pkg::ADDR_LIMITS, d, v);
    chk_word("limits", sft_pkg::LIMITS_RESET, d);
    sft_host_i.rd(8'h3e, d, v);
    chk_word("unmapped", 24'h00_0000, d);
    chk_flag("rvalid", 1'b1, v);
    @(negedge CLOCK);
    FIFO_ENABLE = 1'b1;
    @(negedge CLOCK);
    status();
    for (int r = 0; r < 4; r++) begin
      lim = 24'($urandom());
      sft_host_i.wr(sft_pkg::ADDR_LIMITS, lim);
      sft_host_i.wr(sft_pkg::ADDR_READ_PORT, ~lim);
      clr();
      sft_host_i.rd(sft_pkg::ADDR_LIMITS, d, v);
      chk_word("limits", lim, d);
      CHANNEL_LIMIT_CHECK_ENABLE = (r == 0) ? 16'hffff : 16'($urandom());
      for (int j = 0; j < 4; j++) begin
        d = 24'($urandom());
        if (j == 0) d[23:12] = 12'hfff;
        if (j == 1) d[23:12] = 12'h000;
        push(d, 4'($urandom()));
      end
      @(negedge CLOCK);
      chk_flag("ready when full", 1'b0, CONV_READY);
      for (int j = 0; j < 4; j++) pop();
      sft_host_i.rd(sft_pkg::ADDR_READ_PORT, d, v);
      chk_word("data when empty", 24'h00_0000, d);
    end
    push(24'($urandom()), 4'h1);
    push(24'($urandom()), 4'h2);
    clr();
    push(24'($urandom()), 4'h3);
    @(negedge CLOCK);
    FIFO_ENABLE = 1'b0;
    @(negedge CLOCK);
    q.delete();
    {up_m, lo_m} = 2'b00;
    status();
    FIFO_ENABLE = 1'b1;
    @(negedge CLOCK);
    status();
    results();
  end

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge CLOCK);
    num_errors++;
    results();
  end
endmodule // tb

bind sft_top sft_props sft_props_i (.CLOCK(CLOCK), .RESET_N(RESET_N),
  .FIFO_ENABLE(FIFO_ENABLE), .FIFO_CLEAR(FIFO_CLEAR),
  .CONV_VALID(CONV_VALID), .CONV_READY(CONV_READY),
  .CONV_CHANNEL(CONV_CHANNEL),
  .CHANNEL_LIMIT_CHECK_ENABLE(CHANNEL_LIMIT_CHECK_ENABLE),
  .REG_ADDR(REG_ADDR), .REG_READ(REG_READ), .REG_RVALID(REG_RVALID),
  .EMPTY_FLAG(EMPTY_FLAG), .EMPTY_IRQ(EMPTY_IRQ),
  .UPPER_LIMIT_HIT(UPPER_LIMIT_HIT), .LOWER_LIMIT_HIT(LOWER_LIMIT_HIT),
  .CLEAR_DONE(CLEAR_DONE), .FIFO_LEVEL(FIFO_LEVEL));
